//--- acc_top.sv
/*
  Conversion control of a 10-bit successive-approximation converter:
  control, result and pin-switch registers, software and external
  start, done flag with interrupt request, converter clock divider.
  Assumes the core answers with a one-cycle done pulse and its result,
  and that all inputs are synchronous to REF_CLK.
*/
`timescale 1ns/1ps

module acc_top
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          SYS_RST,
  // Register port
  input  wire logic [7:0]    REG_ADDR,
  input  wire logic [7:0]    REG_WDATA,
  input  wire logic          REG_WR,
  input  wire logic          REG_RD,
  output logic [7:0]         REG_RDATA,
  // Interrupt request
  input  wire logic          IRQ_ENABLE,
  output logic               CONV_IRQ,
  // External trigger pin
  input  wire logic          EXT_START_PIN,
  // Converter core
  output acc_core_req_t      CORE_REQ,
  output logic               CORE_CLK_TICK,
  input  wire acc_core_rsp_t CORE_RSP,
  // Shared pin mode
  output logic [7:0]         ANALOG_PIN_SWITCH
);

  acc_ctl_state_t cur;
  acc_ctl_state_t next_cur;

  logic wr_ctl;
  logic wr_rlo;
  logic wr_psw;
  logic ext_rise;
  logic sw_go;
  logic done_hold;
  logic go;
  logic en_now;

  // Address match for one register
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Write decode and start sources
  always_comb begin
    wr_ctl    = REG_WR && hit(REG_ADDR, ACC_OFS_CTL);
    wr_rlo    = REG_WR && hit(REG_ADDR, ACC_OFS_RLO);
    wr_psw    = REG_WR && hit(REG_ADDR, ACC_OFS_PSW);
    ext_rise  = EXT_START_PIN && !cur.ext_prev;
    sw_go     = wr_ctl && REG_WDATA[ACC_CTL_START_BIT];
    // Writing zero clears done; writing one leaves it alone
    done_hold = cur.done && !(wr_ctl && !REG_WDATA[ACC_CTL_DONE_BIT]);
    // Pin edge counts only with the trigger enabled
    go        = sw_go || (cur.ext_en && ext_rise);
    // Enable as this write leaves it, so one write may enable and start
    en_now    = wr_ctl ? REG_WDATA[ACC_CTL_EN_BIT] : cur.enable;
  end

  // Next state: registers, conversion sequence, read data
  always_comb begin
    next_cur = cur;
    next_cur.start_pulse = 1'b0;
    next_cur.ext_prev = EXT_START_PIN;
    next_cur.done = done_hold;
    next_cur.rdata = 8'h00;

    if (wr_ctl) begin
      next_cur.enable = REG_WDATA[ACC_CTL_EN_BIT];
      next_cur.ext_en = REG_WDATA[ACC_CTL_EXT_BIT];
      // Locked while a conversion is pending or the done flag is set
      if (!cur.done && !cur.busy) begin
        next_cur.channel = REG_WDATA[ACC_CTL_CH_LSB +: 3];
      end
    end
    if (wr_rlo) begin
      next_cur.clksel = REG_WDATA[ACC_RLO_CLK_LSB +: 2];
    end
    if (wr_psw) begin
      next_cur.pin_switch = REG_WDATA;
    end

    case (cur.phase)
      ACC_IDLE: begin
        // Done after this write's clear decides, so clear-plus-start works
        if (en_now && go && !done_hold && !cur.busy) begin
          next_cur.phase = ACC_CONVERT;
          next_cur.busy = 1'b1;
          next_cur.start_pulse = 1'b1;
        end
      end
      ACC_CONVERT: begin
        if (!cur.enable) begin
          // Disabling abandons the conversion with no result
          next_cur.phase = ACC_IDLE;
          next_cur.busy = 1'b0;
        end else if (CORE_RSP.done) begin
          // Flag and both result bytes in one edge; set beats a clear
          next_cur.result = CORE_RSP.result;
          next_cur.done = 1'b1;
          next_cur.phase = ACC_FINISH;
        end
      end
      ACC_FINISH: begin
        // Busy drops one cycle after done rises
        next_cur.busy = 1'b0;
        next_cur.phase = ACC_IDLE;
      end
      default: begin
        next_cur.phase = ACC_IDLE;
        next_cur.busy = 1'b0;
      end
    endcase

    // Request follows the flag; the enable comes from the interrupt controller
    next_cur.irq = cur.done && IRQ_ENABLE;

    // Read data, valid in the cycle after the strobe only
    if (REG_RD) begin
      if (hit(REG_ADDR, ACC_OFS_CTL)) begin
        next_cur.rdata = {cur.enable, 1'b0, cur.ext_en, cur.done, cur.busy, cur.channel};
      end else if (hit(REG_ADDR, ACC_OFS_RLO)) begin
        next_cur.rdata = {cur.clksel, 4'h0, cur.result[1:0]};
      end else if (hit(REG_ADDR, ACC_OFS_RHI)) begin
        next_cur.rdata = cur.result[9:2];
      end else if (hit(REG_ADDR, ACC_OFS_PSW)) begin
        next_cur.rdata = cur.pin_switch;
      end else begin
        next_cur.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cur <= ACC_STATE_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // Converter clock; its rate limit is software's business
  acc_clkdiv #(
    .CNT_W (4)
  ) u_clkdiv (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .run  (cur.enable),
    .sel  (cur.clksel),
    .tick (CORE_CLK_TICK)
  );

  // Outputs straight from state
  assign REG_RDATA         = cur.rdata;
  assign CONV_IRQ          = cur.irq;
  assign CORE_REQ.enable   = cur.enable;
  assign CORE_REQ.start    = cur.start_pulse;
  assign CORE_REQ.channel  = cur.channel;
  assign ANALOG_PIN_SWITCH = cur.pin_switch;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_conv_end;
    cur.phase == ACC_CONVERT && cur.enable && CORE_RSP.done ##1 cur.done && cur.busy;
  endsequence

  sequence s_ext_start;
    cur.phase == ACC_IDLE && en_now && cur.ext_en && ext_rise && !done_hold && !cur.busy;
  endsequence

  AST_ENABLE_GATE: assert property (!en_now |=> !CORE_REQ.start)
    else $error("start issued while converter disabled");

  AST_SW_ONLY: assert property (
    cur.phase == ACC_IDLE && !cur.ext_en && !sw_go |=> !CORE_REQ.start)
    else $error("start without software request while trigger off");

  AST_EXT_START: assert property (s_ext_start |=> CORE_REQ.start && cur.busy)
    else $error("pin edge did not start conversion");

  AST_DONE_IRQ: assert property (
    1'b1 |=> CONV_IRQ == $past(cur.done && IRQ_ENABLE))
    else $error("interrupt request does not follow done flag");

  AST_NO_SW_SET: assert property (
    wr_ctl && REG_WDATA[ACC_CTL_DONE_BIT] && !cur.done && cur.phase != ACC_CONVERT |=> !cur.done)
    else $error("software write set done flag");

  AST_DONE_BLOCKS: assert property (cur.done && done_hold |=> !CORE_REQ.start)
    else $error("start issued while done flag high");

  AST_BUSY_DROPS: assert property (s_conv_end |=> !cur.busy ##1 !cur.busy)
    else $error("busy not cleared after done");

  AST_BUSY_HOLDS: assert property (
    cur.phase == ACC_CONVERT && cur.enable && !CORE_RSP.done |=> cur.busy && !CORE_REQ.start)
    else $error("busy lost or restart during conversion");

  AST_CHAN_LOCK: assert property ((cur.busy || cur.done) |=> $stable(cur.channel))
    else $error("channel changed while locked");

  AST_RESULT_LOAD: assert property (
    cur.phase == ACC_CONVERT && cur.enable && CORE_RSP.done
    |=> cur.result == $past(CORE_RSP.result) && cur.done)
    else $error("result not loaded with done flag");

  AST_RO_RESULT: assert property (
    (wr_rlo || REG_WR) && cur.phase != ACC_CONVERT |=> $stable(cur.result))
    else $error("write changed result bits");

  AST_READ_HIGH: assert property (
    REG_RD && REG_ADDR == ACC_OFS_RHI |=> REG_RDATA == $past(cur.result[9:2]))
    else $error("high result read mismatch");

endmodule

//--- acc_pkg.sv
/*
  Shared constants and types of the converter control block: register
  offsets, field positions, reset values, divider settings and the
  state record. Assumes an 8-bit register port and a 10-bit converter core.
*/
package acc_pkg;

  // Register offsets
  localparam logic [7:0] ACC_OFS_CTL = 8'hC0;
  localparam logic [7:0] ACC_OFS_RLO = 8'hC1;
  localparam logic [7:0] ACC_OFS_RHI = 8'hC2;
  localparam logic [7:0] ACC_OFS_PSW = 8'hC6;

  // Field positions
  localparam int ACC_CTL_EN_BIT    = 7;
  localparam int ACC_CTL_EXT_BIT   = 5;
  localparam int ACC_CTL_DONE_BIT  = 4;
  localparam int ACC_CTL_START_BIT = 3;
  localparam int ACC_CTL_CH_LSB    = 0;
  localparam int ACC_RLO_CLK_LSB   = 6;

  // Reset values
  localparam logic [1:0] ACC_CLKSEL_RST = 2'h0;
  localparam logic [7:0] ACC_PSW_RST    = 8'h00;

  // Converter clock select codes and divisors
  localparam logic [1:0] ACC_CLK_DIV4  = 2'h0;
  localparam logic [1:0] ACC_CLK_DIV8  = 2'h1;
  localparam logic [1:0] ACC_CLK_DIV16 = 2'h2;
  localparam logic [4:0] ACC_DIV4      = 5'h04;
  localparam logic [4:0] ACC_DIV8      = 5'h08;
  localparam logic [4:0] ACC_DIV16     = 5'h10;

  typedef enum logic [1:0] {
    ACC_IDLE    = 2'b00,
    ACC_CONVERT = 2'b01,
    ACC_FINISH  = 2'b10
  } acc_phase_t;

  // Requests to the converter core
  typedef struct packed {
    logic       enable;
    logic       start;
    logic [2:0] channel;
  } acc_core_req_t;

  // Answer from the converter core
  typedef struct packed {
    logic       done;
    logic [9:0] result;
  } acc_core_rsp_t;

  // Whole state of the control block
  typedef struct packed {
    acc_phase_t phase;
    logic       enable;
    logic       ext_en;
    logic       done;
    logic       busy;
    logic [2:0] channel;
    logic [1:0] clksel;
    logic [9:0] result;
    logic [7:0] pin_switch;
    logic       ext_prev;
    logic [7:0] rdata;
    logic       start_pulse;
    logic       irq;
  } acc_ctl_state_t;

  localparam acc_ctl_state_t ACC_STATE_RST = '{
    phase:      ACC_IDLE,
    clksel:     ACC_CLKSEL_RST,
    pin_switch: ACC_PSW_RST,
    default:    '0
  };

endpackage

//--- acc_clkdiv.sv
/*
  Converter clock divider: one-cycle tick every 4, 8 or 16 reference
  cycles. Assumes the select code may change at any time.
*/
`timescale 1ns/1ps
module acc_clkdiv
  import acc_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // Tick to the converter core
  output logic            tick
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } acc_div_state_t;

  acc_div_state_t cur;
  acc_div_state_t next_cur;

  // Counter must reach the largest divisor minus one
  if (CNT_W < 4) begin : g_bad_width
    $error("acc_clkdiv: CNT_W must be at least 4");
  end

  // Last count of one converter clock period
  function automatic logic [CNT_W-1:0] last_count(input logic [1:0] s);
    logic [4:0] div;
    case (s)
      ACC_CLK_DIV4: div = ACC_DIV4;
      ACC_CLK_DIV8: div = ACC_DIV8;
      default:      div = ACC_DIV16; // Reserved code runs at the slowest rate
    endcase
    return CNT_W'(div - 5'h01);
  endfunction

  // Counting; a late select change is caught by the >= compare
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (!run) begin
      next_cur.count = '0;
    end else if (cur.count >= last_count(sel)) begin
      next_cur.count = '0;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.count = cur.count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;

endmodule

//--- acc_core_model.sv
/*
  Behavioural converter core standing behind acc_top in the bench.
  Assumes requests and ticks arrive synchronous to the rising clock edge.
*/
`timescale 1ns/1ps
module acc_core_model
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // From the control block
  input  wire acc_core_req_t req,
  input  wire logic          tick,
  // Bench settings: ticks per conversion, result to return
  input  wire logic [4:0]    ticks,
  input  wire logic [9:0]    value,
  // Answer
  output acc_core_rsp_t      rsp
);
  logic       run;
  logic [4:0] cnt;

  // Result toggles outside done so a stale value never passes for fresh
  always @(posedge clk) begin
    rsp.done <= 1'b0;
    rsp.result <= ~rsp.result;
    if (rst || !req.enable) begin
      run <= 1'b0;
      cnt <= 5'h00;
      rsp.result <= 10'h2AA;
    end else if (req.start) begin
      run <= 1'b1;
      cnt <= 5'h00;
    end else if (run && tick) begin
      cnt <= cnt + 5'h01;
      if (cnt + 5'h01 == ticks) begin
        run <= 1'b0;
        rsp.done <= 1'b1;
        rsp.result <= value;
      end
    end
  end
endmodule

//--- acc_top_bench.sv
/*
  Self-checking bench of acc_top with a behavioural converter core.
  Assumes a 40 MHz clock and registers reset to zero.
*/
`timescale 1ns/1ps
module acc_top_bench
  import acc_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    addr = 8'h00;
  logic [7:0]    wdata = 8'h00;
  logic          wr_s = 1'b0;
  logic          rd_s = 1'b0;
  logic [7:0]    rdata;
  logic          irq_en = 1'b1;
  logic          irq;
  logic          ext_pin = 1'b0;
  acc_core_req_t req;
  logic          tick;
  acc_core_rsp_t rsp;
  logic [7:0]    psw;
  logic [4:0]    ticks = 5'h0A;
  logic [9:0]    value = 10'h2B7;
  int            n_fail = 0;
  int            samples_checked = 0;
  int            n_start = 0;
  int            n_tick = 0;
  int            cyc = 0;
  int            k;

  acc_top acc_top_inst (.REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .IRQ_ENABLE(irq_en), .CONV_IRQ(irq),
    .EXT_START_PIN(ext_pin), .CORE_REQ(req), .CORE_CLK_TICK(tick), .CORE_RSP(rsp),
    .ANALOG_PIN_SWITCH(psw));
  acc_core_model acc_core_model_inst (.clk(clk), .rst(rst), .req(req), .tick(tick),
    .ticks(ticks), .value(value), .rsp(rsp));

  // 25 ns period
  always #12.5 clk = ~clk;

  // Pulses counted mid-cycle, clear of the edge that launches them
  always @(negedge clk) begin
    if (tick === 1'b1) n_tick++;
    if (req.start === 1'b1) n_start++;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Gap after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk({2'h0, rdata}, {2'h0, exp}, "read");
    @(posedge clk);
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 600 && rsp.done !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse_ext();
    ext_pin <= 1'b1;
    repeat (3) @(posedge clk);
    ext_pin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [7:0] al [5];
    al = '{ACC_OFS_CTL, ACC_OFS_RLO, ACC_OFS_RHI, ACC_OFS_PSW, 8'hC3};
    foreach (al[i]) rd(al[i], 8'h00);
    chk({5'h00, req}, 10'h000, "core request");
    wr(ACC_OFS_RLO, 8'h80);
    $display("test reset done");
  endtask

  task automatic t_sw_conv();
    wr(ACC_OFS_CTL, 8'h8D);
    chk({7'h00, req.channel}, 10'h005, "channel");
    rd(ACC_OFS_CTL, 8'h8D);
    wait_done();
    rd(ACC_OFS_CTL, 8'h95);
    chk({9'h000, irq}, 10'h001, "irq");
    rd(ACC_OFS_RHI, 8'hAD);
    rd(ACC_OFS_RLO, 8'h83);
    wr(ACC_OFS_CTL, 8'h9A);
    rd(ACC_OFS_CTL, 8'h95);
    chk(10'(n_start), 10'h001, "start while done");
    wr(ACC_OFS_CTL, 8'h85);
    rd(ACC_OFS_CTL, 8'h85);
    chk({9'h000, irq}, 10'h000, "irq clear");
    wr(ACC_OFS_CTL, 8'h92);
    rd(ACC_OFS_CTL, 8'h82);
    chk({7'h00, req.channel}, 10'h002, "channel");
    $display("test software conversion done");
  endtask

  task automatic t_busy();
    ticks <= 5'h14;
    wr(ACC_OFS_CTL, 8'h8A);
    wr(ACC_OFS_CTL, 8'h83);
    rd(ACC_OFS_CTL, 8'h8A);
    wr(ACC_OFS_CTL, 8'h8C);
    chk(10'(n_start), 10'h002, "start while busy");
    wait_done();
    rd(ACC_OFS_CTL, 8'h92);
    wr(ACC_OFS_CTL, 8'h8F);
    chk(10'(n_start), 10'h003, "clear and start");
    chk({7'h00, req.channel}, 10'h002, "same channel");
    wait_done();
    wr(ACC_OFS_CTL, 8'h82);
    ticks <= 5'h0A;
    $display("test busy done");
  endtask

  task automatic t_ext();
    pulse_ext();
    chk(10'(n_start), 10'h003, "pin ignored");
    wr(ACC_OFS_CTL, 8'hA2);
    pulse_ext();
    chk(10'(n_start), 10'h004, "pin start");
    wait_done();
    pulse_ext();
    chk(10'(n_start), 10'h004, "pin while done");
    irq_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk({9'h000, irq}, 10'h000, "irq masked");
    irq_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk({9'h000, irq}, 10'h001, "irq unmasked");
    wr(ACC_OFS_CTL, 8'hA2);
    rd(ACC_OFS_CTL, 8'hA2);
    $display("test external start done");
  endtask

  task automatic t_clk();
    int n0;
    int dv [4];
    dv = '{16, 8, 4, 4};
    for (k = 0; k < 4; k++) begin
      wr(ACC_OFS_RLO, {k[1:0], 6'h3F});
      n0 = n_tick;
      repeat (64) @(posedge clk);
      chk(10'(n_tick - n0), 10'(dv[k]), "ticks");
      rd(ACC_OFS_RLO, {k[1:0], 6'h03});
    end
    wr(ACC_OFS_RLO, 8'h80);
    $display("test clock select done");
  endtask

  task automatic t_off();
    int n0;
    wr(ACC_OFS_CTL, 8'h08);
    n0 = n_tick;
    repeat (32) @(posedge clk);
    chk(10'(n_tick - n0), 10'h000, "ticks off");
    chk(10'(n_start), 10'h004, "start off");
    chk({9'h000, req.enable}, 10'h000, "enable");
    wr(ACC_OFS_PSW, 8'hA5);
    chk({2'h0, psw}, 10'h0A5, "pin switch");
    rd(ACC_OFS_PSW, 8'hA5);
    wr(8'hC3, 8'hFF);
    rd(8'hC3, 8'h00);
    wr(ACC_OFS_RHI, 8'h00);
    rd(ACC_OFS_RHI, 8'hAD);
    $display("test disable and pin switch done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_sw_conv();
    t_busy();
    t_ext();
    t_clk();
    t_off();
    wrap_up();
  end
endmodule
